// ---- hdl/lrhp_pkg.sv ----
// Constants, field layouts and types for the LED display and host port block
package lrhp_pkg;

  // Core clock and documented times
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned LED_TEST_S    = 1;     // LED test length, seconds
  localparam int unsigned FREEZE_MS     = 30;    // Display freeze, ms
  localparam int unsigned LED_TEST_CYC  = CLK_HZ * LED_TEST_S;
  localparam int unsigned FREEZE_CYC    = (CLK_HZ / 1000) * FREEZE_MS;

  // Display cycle pacing, in core cycles
  localparam logic [3:0]  SETUP_CYC     = 4'h2;  // Data valid before strobe
  localparam logic [3:0]  HOLD_CYC      = 4'h2;  // Data held after strobe
  localparam int          TMR_W         = 26;    // Wide enough for 1 s

  // Pin bus layout
  localparam int          ADDR_LSB      = 5;     // Port address D(7:5)
  localparam int          NIB_LSB       = 4;     // Register address D(7:4)
  localparam int          CFG_MODE_BIT  = 7;     // Max/min strap on D7
  localparam int          CFG_BYP_LSB   = 0;     // Bypass straps on D(1:0)
  localparam int          BIT_LINK      = 0;
  localparam int          BIT_CLASH     = 1;
  localparam int          BIT_RX        = 2;
  localparam int          BIT_ISO       = 3;
  localparam int          BIT_POL       = 4;
  localparam logic [2:0]  AGG_ADDR      = 3'h0;
  localparam logic [2:0]  FIRST_TP_PORT = 3'h2;  // Ports with link/polarity

  // Output enable codes, low means driven
  localparam logic [7:0]  OE_ALL_OFF    = 8'hff;
  localparam logic [7:0]  OE_ALL_ON     = 8'h00;
  localparam logic [7:0]  OE_LOW_NIB    = 8'hf0;

  // Ports using the internal twisted-pair transceiver, per bypass strap
  localparam logic [7:1]  INT_NONE      = 7'h00;
  localparam logic [7:1]  INT_P4_P7     = 7'h78;
  localparam logic [7:1]  INT_P6_P7     = 7'h60;
  localparam logic [7:1]  INT_P2_P7     = 7'h7e;

  // Live repeater status from the core
  typedef struct packed {
    logic       clash_any;
    logic       rx_any;
    logic       babble;
    logic       isolated_any;
    logic [7:1] link;
    logic [7:1] clash;
    logic [7:1] rx;
    logic [7:1] isolated;
    logic [7:1] polarity;
  } lrhp_status_t;

  typedef enum logic [1:0] {
    DSP_SETUP,
    DSP_STROBE,
    DSP_HOLD,
    HOST_ACC
  } lrhp_phase_t;

endpackage : lrhp_pkg

// ---- hdl/lrhp_sync.sv ----
// Two-flop synchroniser for the block's pin inputs
module lrhp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,  // Core clock
  input  wire logic         srst, // Sync reset, high
  input  wire logic [W-1:0] d,    // Asynchronous pins
  output logic      [W-1:0] q     // Synchronised copy
);

  logic [W-1:0] meta_q;

  // Idle pins are high, so reset to ones to avoid false strobes
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : lrhp_sync

// ---- hdl/lrhp_display_port.sv ----
// LED status display and nibble-wide host register port
module lrhp_display_port
  import lrhp_pkg::*;
#(
  parameter int unsigned TEST_CYC   = LED_TEST_CYC,
  parameter int unsigned FRZ_CYC    = FREEZE_CYC
) (
  input  wire logic         clk,                    // Core clock
  input  wire logic         srst,                   // Sync reset, high
  input  wire logic         config_capture_reset_n, // Config/reset pin
  input  wire logic         host_rd_n,              // Host read strobe
  input  wire logic         host_wr_n,              // Host write strobe
  input  wire logic [7:0]   data_in,                // Data pins, sensed
  output logic      [7:0]   data_out,               // Data pins, driven
  output logic      [7:0]   data_oe_n,              // Pin enables, low drives
  input  wire lrhp_status_t status,                 // Live core status
  input  wire logic         pkt_active,             // Packet being repeated
  input  wire logic [3:0]   reg_rdata,              // Nibble at reg_addr
  output logic              led_latch_pulse,        // LED latch strobe
  output logic              freeze_pulse,           // Packet end strobe
  output logic              transceiver_gate_n,     // Bus buffer enable
  output logic              repeat_inhibit,         // LED test in progress
  output logic              core_reset,             // Reset to core logic
  output logic              max_mode,               // Captured format
  output logic      [3:0]   reg_addr,               // Host nibble address
  output logic      [3:0]   reg_wdata,              // Host write nibble
  output logic              reg_wr_pulse,           // Write nibble commit
  output logic              reg_rd_pulse            // Read nibble done
);

  typedef struct packed {
    lrhp_phase_t        phase;
    logic [3:0]         ph_cnt;
    logic [2:0]         disp_addr;
    logic               max_mode;
    logic [1:0]         bypass;
    logic               config_capture_reset_prev;
    logic               test_on;
    logic [TMR_W-1:0]   test_cnt;
    logic               frozen;
    logic [TMR_W-1:0]   frz_cnt;
    lrhp_status_t       snap;
    logic               pkt_prev;
    logic               is_write;
    logic [7:0]         data_out;
    logic [7:0]         data_oe_n;
    logic               latch;
    logic               freeze;
    logic               gate_n;
    logic               inhibit;
    logic               core_reset;
    logic [3:0]         reg_addr;
    logic [3:0]         reg_wdata;
    logic               wr_pulse;
    logic               rd_pulse;
  } lrhp_state_t;

  lrhp_state_t  q;
  lrhp_state_t  n;
  logic [10:0]  pins_s;
  logic         config_capture_reset_s;
  logic         rd_s_n;
  logic         wr_s_n;
  logic [7:0]   din_s;
  logic [7:1]   int_mask;

  // All pins cross into the core clock through one synchroniser
  lrhp_sync #(
    .W (11)
  ) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({config_capture_reset_n, host_rd_n, host_wr_n, data_in}),
    .q    (pins_s)
  );

  assign config_capture_reset_s = pins_s[10];
  assign rd_s_n  = pins_s[9];
  assign wr_s_n  = pins_s[8];
  assign din_s   = pins_s[7:0];

  // Ports whose polarity indication is meaningful
  always_comb begin
    case (q.bypass)
      2'h0:    int_mask = INT_NONE;
      2'h1:    int_mask = INT_P4_P7;
      2'h2:    int_mask = INT_P6_P7;
      default: int_mask = INT_P2_P7;
    endcase
  end

  // Pin word for one display slot; test forces every used LED on
  function automatic logic [7:0] disp_word(
    input logic [2:0]   a,
    input logic         mx,
    input logic         tst,
    input lrhp_status_t s,
    input logic [7:1]   intl
  );
    logic [7:0] w;
    logic [3:0] agg;
    logic       tp;
    w   = 8'h00;
    tp  = (a >= FIRST_TP_PORT);
    agg = tst ? 4'hf : {s.isolated_any, s.babble, s.rx_any, s.clash_any};
    if (!mx || a == AGG_ADDR) begin
      w[BIT_ISO:BIT_LINK] = agg;
    end else begin
      w[BIT_LINK]  = tp && (tst || s.link[a]);
      w[BIT_CLASH] = tst || s.clash[a];
      w[BIT_RX]    = tst || s.rx[a];
      w[BIT_ISO]   = tst || s.isolated[a];
      w[BIT_POL]   = tp && intl[a] && (tst || s.polarity[a]);
    end
    if (mx) begin
      w[ADDR_LSB +: 3] = a;
    end
    return w;
  endfunction : disp_word

  // Next-state logic for display, freeze, test and host access
  always_comb begin
    n            = q;
    n.latch      = 1'b0;
    n.freeze     = 1'b0;
    n.wr_pulse   = 1'b0;
    n.rd_pulse   = 1'b0;
    n.config_capture_reset_prev = config_capture_reset_s;
    n.pkt_prev   = pkt_active;
    // Snapshot at packet end; a new packet or timeout releases it
    if (q.pkt_prev && !pkt_active) begin
      n.freeze  = 1'b1;
      n.frozen  = 1'b1;
      n.frz_cnt = TMR_W'(FRZ_CYC - 1);
      n.snap    = status;
    end else if (pkt_active) begin
      n.frozen  = 1'b0;
    end else if (q.frozen) begin
      if (q.frz_cnt == '0) begin
        n.frozen = 1'b0;
      end else begin
        n.frz_cnt = q.frz_cnt - 1'b1;
      end
    end
    if (q.test_on) begin
      if (q.test_cnt == '0) begin
        n.test_on = 1'b0;
      end else begin
        n.test_cnt = q.test_cnt - 1'b1;
      end
    end
    // Straps are read on the rising edge of the config pin
    if (!q.config_capture_reset_prev && config_capture_reset_s) begin
      n.max_mode = din_s[CFG_MODE_BIT];
      n.bypass   = din_s[CFG_BYP_LSB +: 2];
      n.test_on  = 1'b1;
      n.test_cnt = TMR_W'(TEST_CYC - 1);
    end
    // Display cycles need no host; the host only gets a slot between them
    case (q.phase)
      DSP_SETUP: begin
        if (q.ph_cnt == SETUP_CYC - 4'h1) begin
          n.phase  = DSP_STROBE;
          n.ph_cnt = 4'h0;
          n.latch  = 1'b1;
        end else begin
          n.ph_cnt = q.ph_cnt + 4'h1;
        end
      end
      DSP_STROBE: begin
        n.phase = DSP_HOLD;
      end
      DSP_HOLD: begin
        if (q.ph_cnt < HOLD_CYC - 4'h1) begin
          n.ph_cnt = q.ph_cnt + 4'h1;
        end else if (!rd_s_n || !wr_s_n) begin
          n.phase     = HOST_ACC;
          n.gate_n    = 1'b0;
          n.is_write  = !wr_s_n;
          n.data_oe_n = !wr_s_n ? OE_ALL_OFF : OE_LOW_NIB;
          n.reg_addr  = din_s[NIB_LSB +: 4];
        end else begin
          n.phase     = DSP_SETUP;
          n.ph_cnt    = 4'h0;
          n.disp_addr = q.max_mode ? q.disp_addr + 3'h1 : AGG_ADDR;
          n.data_oe_n = OE_ALL_ON;
          n.data_out  = disp_word(n.disp_addr, q.max_mode, q.test_on,
                                  q.frozen ? q.snap : status, int_mask);
        end
      end
      HOST_ACC: begin
        // D7 picks the nibble; the register side does the selection
        n.reg_addr = din_s[NIB_LSB +: 4];
        if (q.is_write) begin
          n.reg_wdata = din_s[3:0];
        end else begin
          n.data_out  = {4'h0, reg_rdata};
        end
        if (rd_s_n && wr_s_n) begin
          n.phase     = DSP_HOLD;                          // Turnaround gap
          n.ph_cnt    = 4'h0;
          n.gate_n    = 1'b1;
          n.data_oe_n = OE_ALL_OFF;
          n.wr_pulse  = q.is_write;
          n.rd_pulse  = !q.is_write;
          n.reg_addr  = q.reg_addr;                        // Last valid addr
        end
      end
      default: begin
        n.phase = DSP_HOLD;
      end
    endcase
    // Config pin low: stop the display, float pins, reset the core
    if (!config_capture_reset_s) begin
      // A slot aborted in DSP_SETUP gives its address back; one aborted as it leaves DSP_HOLD uses its address up
      if (q.phase == DSP_SETUP) begin
        n.disp_addr = q.disp_addr - 3'h1;
      end
      n.phase     = DSP_HOLD;
      n.ph_cnt    = 4'h0;
      n.data_oe_n = OE_ALL_OFF;
      n.gate_n    = 1'b1;
      n.latch     = 1'b0;
      n.frozen    = 1'b0;
      n.test_on   = 1'b0;
    end
    n.core_reset = !config_capture_reset_s;
    n.inhibit    = n.test_on;
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      q            <= '0;
      q.phase      <= DSP_HOLD;
      q.config_capture_reset_prev <= 1'b1;
      q.data_oe_n  <= OE_ALL_OFF;
      q.gate_n     <= 1'b1;
      q.core_reset <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign data_out           = q.data_out;
  assign data_oe_n          = q.data_oe_n;
  assign led_latch_pulse    = q.latch;
  assign freeze_pulse       = q.freeze;
  assign transceiver_gate_n = q.gate_n;
  assign repeat_inhibit     = q.inhibit;
  assign core_reset         = q.core_reset;
  assign max_mode           = q.max_mode;
  assign reg_addr           = q.reg_addr;
  assign reg_wdata          = q.reg_wdata;
  assign reg_wr_pulse       = q.wr_pulse;
  assign reg_rd_pulse       = q.rd_pulse;

  // Helper: last strobed address, for the address walk check
  logic [2:0] chk_addr_q;
  logic       chk_seen_q;
  always_ff @(posedge clk) begin
    if (srst || !q.max_mode || !q.gate_n) begin
      chk_addr_q <= 3'h0;
      chk_seen_q <= 1'b0;
    end else if (q.latch) begin
      chk_addr_q <= q.data_out[ADDR_LSB +: 3];
      chk_seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_strobe_data;
    led_latch_pulse |-> data_oe_n == OE_ALL_ON && $stable(data_out);
  endproperty
  a_strobe_data: assert property (p_strobe_data)
    else $error("latch strobe without stable driven data");

  property p_min_upper;
    led_latch_pulse && !max_mode |-> data_out[7:4] == 4'h0;
  endproperty
  a_min_upper: assert property (p_min_upper)
    else $error("min format upper nibble not zero");

  property p_addr_walk;
    led_latch_pulse && chk_seen_q && transceiver_gate_n
      |-> data_out[ADDR_LSB +: 3] == 3'(chk_addr_q + 3'h1);
  endproperty
  a_addr_walk: assert property (p_addr_walk)
    else $error("display address did not advance by one");

  property p_port1_no_link;
    led_latch_pulse && max_mode && data_out[7:5] == 3'h1
      |-> !data_out[BIT_LINK] && !data_out[BIT_POL];
  endproperty
  a_port1_no_link: assert property (p_port1_no_link)
    else $error("port 1 shows link or polarity");

  property p_host_write_float;
    q.phase == HOST_ACC && q.is_write |-> data_oe_n == OE_ALL_OFF;
  endproperty
  a_host_write_float: assert property (p_host_write_float)
    else $error("data pins driven during host write");

  property p_gate_after_hold;
    $fell(transceiver_gate_n) |-> $past(q.phase) == DSP_HOLD && !led_latch_pulse;
  endproperty
  a_gate_after_hold: assert property (p_gate_after_hold)
    else $error("buffer enabled inside a display cycle");

  property p_freeze_strobe;
    $fell(pkt_active) && config_capture_reset_s |=> freeze_pulse ##1 !freeze_pulse;
  endproperty
  a_freeze_strobe: assert property (p_freeze_strobe)
    else $error("freeze strobe missing at packet end");

  property p_freeze_release;
    $rose(pkt_active) |=> !q.frozen;
  endproperty
  a_freeze_release: assert property (p_freeze_release)
    else $error("freeze not released by new packet");

  property p_test_inhibit;
    $rose(config_capture_reset_s) |=> ##1 repeat_inhibit [*8];
  endproperty
  a_test_inhibit: assert property (p_test_inhibit)
    else $error("repetition not inhibited during LED test");

  property p_test_lights;
    led_latch_pulse && repeat_inhibit |-> data_out[BIT_ISO:BIT_LINK] != 4'h0
      && (max_mode || data_out[BIT_ISO:BIT_LINK] == 4'hf);
  endproperty
  a_test_lights: assert property (p_test_lights)
    else $error("LED test does not light the LEDs");

  property p_core_reset;
    !config_capture_reset_s |=> core_reset && transceiver_gate_n;
  endproperty
  a_core_reset: assert property (p_core_reset)
    else $error("core not held in reset while config pin low");

endmodule : lrhp_display_port

// ---- test/lrhp_far_model.sv ----
// Far side model: LED latches, pin resolution and transceiver straps
module lrhp_far_model
  import lrhp_pkg::*;
(
  input  wire logic       clk,                // Core clock
  input  wire logic [7:0] data_out,           // Pins driven by the block
  input  wire logic [7:0] data_oe_n,          // Block enables, low drives
  input  wire logic [7:0] ext_val,            // Straps or transceiver drive
  input  wire logic       led_latch_pulse,    // Latch strobe
  input  wire logic       transceiver_gate_n, // Buffer enable
  input  wire logic       max_mode,           // Addressed latches in use
  output logic      [7:0] pins,               // Resolved pin levels
  output logic      [4:0] lat [8],            // Addressable latch bits
  output logic      [7:0] oct_q,              // Octal holding latch
  output int              errs                // Protocol slips seen
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] prev_q;
  logic [2:0] addr_q;
  int         gap_q = 99;

  // Each pin shows the block's drive where enabled, else the far side
  assign pins = (data_out & ~data_oe_n) | (ext_val & data_oe_n);

  // Latches capture on the strobe; slips are counted for the bench
  always @(posedge clk) begin
    prev_q <= data_out;
    gap_q  <= gap_q + 1;
    if (led_latch_pulse) begin
      gap_q          <= 0;
      addr_q         <= pins[7:5];
      oct_q          <= pins;
      lat[pins[7:5]] <= pins[4:0];
      // Data must sit a cycle ahead, with the bus owned by the block
      errs <= errs + int'(data_out !== prev_q || data_oe_n !== 8'h00)
            + int'(transceiver_gate_n !== 1'b1)
            + int'(max_mode && gap_q < 12
                   && pins[7:5] !== addr_q + 3'h1);
    end
  end
endmodule : lrhp_far_model

// ---- test/tb_top.sv ----
// Self-checking bench for the LED display and host port block
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  fails++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top
  import lrhp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned TC = 200;
  localparam int unsigned FC = 120;

  logic         clk = 1'b0;
  logic         srst, cfg_n, rd_n, wr_n, pkt_active;
  logic [7:0]   ext_val, pins, data_out, data_oe_n, oct_q;
  logic [4:0]   far_lat [8];
  logic [3:0]   reg_rdata, reg_addr, reg_wdata;
  logic         led_latch_pulse, freeze_pulse, transceiver_gate_n;
  logic         repeat_inhibit, core_reset, max_mode;
  logic         reg_wr_pulse, reg_rd_pulse;
  lrhp_status_t st, st_a;
  int           fails, total_checks, far_errs, cyc, cnt;

  // Register file stand-in: each nibble reads back inverted address
  assign reg_rdata = ~reg_addr;

  lrhp_display_port #(.TEST_CYC(TC), .FRZ_CYC(FC)) lrhp_display_port_inst (
    .clk(clk), .srst(srst), .config_capture_reset_n(cfg_n),
    .host_rd_n(rd_n), .host_wr_n(wr_n), .data_in(pins),
    .data_out(data_out), .data_oe_n(data_oe_n), .status(st),
    .pkt_active(pkt_active), .reg_rdata(reg_rdata),
    .led_latch_pulse(led_latch_pulse), .freeze_pulse(freeze_pulse),
    .transceiver_gate_n(transceiver_gate_n),
    .repeat_inhibit(repeat_inhibit), .core_reset(core_reset),
    .max_mode(max_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr_pulse(reg_wr_pulse), .reg_rd_pulse(reg_rd_pulse));

  lrhp_far_model lrhp_far_model_inst (
    .clk(clk), .data_out(data_out), .data_oe_n(data_oe_n),
    .ext_val(ext_val), .led_latch_pulse(led_latch_pulse),
    .transceiver_gate_n(transceiver_gate_n), .max_mode(max_mode),
    .pins(pins), .lat(far_lat), .oct_q(oct_q), .errs(far_errs));

  // 40 MHz core clock
  always #12.5 clk = ~clk;

  // Hang guard, sized well above the whole sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  // Expected latch word for one address, worked out from the status
  function automatic logic [4:0] exp_word(input int a, input logic tst,
                                          input logic [1:0] b,
                                          input lrhp_status_t s);
    logic intl;
    intl = a >= 2 && (b == 2'h3 || (b == 2'h1 && a >= 4)
           || (b == 2'h2 && a >= 6));
    if (a == 0)
      return tst ? 5'h0f : {1'b0, s.isolated_any, s.babble, s.rx_any,
                            s.clash_any};
    if (tst)
      return {intl, 3'h7, a >= 2};
    return {s.polarity[a] & intl, s.isolated[a], s.rx[a], s.clash[a],
            s.link[a] & (a >= 2)};
  endfunction : exp_word

  task automatic check_leds(input logic mx, input logic tst,
                            input logic [1:0] b, input lrhp_status_t s);
    logic [4:0] w;
    for (int a = 0; a < 8; a++) begin
      w = exp_word(a, tst, b, s);
      if (mx) `CHK("led latch", w, far_lat[a])
    end
    w = exp_word(0, tst, b, s);
    if (!mx) `CHK("min latch", w[3:0], oct_q[3:0])
  endtask : check_leds

  // Pull the config pin low, set straps, release and watch the LED test
  task automatic configure(input logic mx, input logic [1:0] b);
    int n;
    @(negedge clk);
    cfg_n   <= 1'b0;
    ext_val <= {mx, 4'h6, 1'b1, b};
    repeat (6) @(negedge clk);
    `CHK("core held", 1'b1, core_reset)
    `CHK("pins released", 8'hff, data_oe_n)
    cfg_n <= 1'b1;
    for (n = 0; n < 10 && repeat_inhibit !== 1'b1; n++) @(negedge clk);
    `CHK("format", mx, max_mode)
    `CHK("core released", 1'b0, core_reset)
    repeat (60) @(negedge clk);
    check_leds(mx, 1'b1, b, st);
    for (n = 60; n < TC + 20 && repeat_inhibit === 1'b1; n++)
      @(negedge clk);
    `CHK("test length", TC, n)
    $display("config mx=%0d straps=%0d done", mx, b);
  endtask : configure

  // One host nibble access through the transceiver
  task automatic host_acc(input logic wr, input logic [3:0] a,
                          input logic [3:0] d);
    int i;
    @(negedge clk);
    ext_val <= {a, d};
    if (wr) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    for (i = 0; i < 30 && transceiver_gate_n !== 1'b0; i++) @(negedge clk);
    `CHK("gate low", 1'b0, transceiver_gate_n)
    // Address crosses the synchroniser before read data can follow it
    repeat (5) @(negedge clk);
    `CHK("pin enables", wr ? 8'hff : 8'hf0, data_oe_n)
    if (!wr) `CHK("read nibble", ~a, pins[3:0])
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    for (i = 0; i < 10 && (wr ? reg_wr_pulse : reg_rd_pulse) !== 1'b1; i++)
      @(negedge clk);
    `CHK("commit pulse", 1'b1, wr ? reg_wr_pulse : reg_rd_pulse)
    `CHK("nibble address", a, reg_addr)
    if (wr) `CHK("write nibble", d, reg_wdata)
    repeat (4) @(negedge clk);
  endtask : host_acc

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  initial begin
    srst       = 1'b1;
    cfg_n      = 1'b1;
    rd_n       = 1'b1;
    wr_n       = 1'b1;
    pkt_active = 1'b0;
    ext_val    = 8'h00;
    st         = '0;
    repeat (12) @(negedge clk);
    srst <= 1'b0;
    // Max format under every strap setting
    for (int b = 0; b < 4; b++) begin
      configure(1'b1, 2'(b));
      st <= {4'(b + 5), 7'h7f, 7'(b * 9 + 3), 7'(b * 5 + 33),
             7'(b * 17 + 6), 7'h7f};
      repeat (60) @(negedge clk);
      check_leds(1'b1, 1'b0, 2'(b), st);
    end
    // Freeze held, then expired by time
    st_a = st;
    pkt_active <= 1'b1;
    repeat (5) @(negedge clk);
    pkt_active <= 1'b0;
    cnt = 0;
    repeat (4) begin
      @(negedge clk);
      if (freeze_pulse === 1'b1) cnt++;
    end
    `CHK("freeze pulse", 1, cnt)
    st <= ~st_a;
    repeat (45) @(negedge clk);
    check_leds(1'b1, 1'b0, 2'h3, st_a);
    repeat (FC + 60) @(negedge clk);
    check_leds(1'b1, 1'b0, 2'h3, ~st_a);
    // Freeze released early by the next packet
    pkt_active <= 1'b1;
    repeat (5) @(negedge clk);
    pkt_active <= 1'b0;
    repeat (3) @(negedge clk);
    st <= st_a;
    repeat (2) @(negedge clk);
    pkt_active <= 1'b1;
    repeat (60) @(negedge clk);
    check_leds(1'b1, 1'b0, 2'h3, st_a);
    $display("freeze done");
    // Host nibble writes and reads, both nibble halves
    host_acc(1'b1, 4'h3, 4'ha);
    host_acc(1'b1, 4'hb, 4'h5);
    host_acc(1'b0, 4'h5, 4'h0);
    host_acc(1'b0, 4'hd, 4'h0);
    $display("host port done");
    // Min format
    configure(1'b0, 2'h0);
    repeat (60) @(negedge clk);
    check_leds(1'b0, 1'b0, 2'h0, st);
    $display("min format done");
    `CHK("far side slips", 0, far_errs)
    final_report();
  end
endmodule : tb_top
